// file: phr_map.vh
// register offsets, field layout and reset values of the pad hysteresis bank
`ifndef PHR_MAP_VH
`define PHR_MAP_VH
`define PHR_OFF_GRPB       8'he4
`define PHR_OFF_GRPC       8'he8
`define PHR_MASK_LSB       16
`define PHR_MASK_MSB       31
`define PHR_HYST_LSB       0
`define PHR_HYST_MSB       7
`define PHR_HYST_RESET     8'h00
`define PHR_ADDR_W         8
`endif

// file: phr_masked_byte.v
// one eight-bit hysteresis field with per-bit masked update
`include "phr_map.vh"
`default_nettype none
module phr_masked_byte #(
    parameter WIDTH = 8
) (
    // clock and reset
    input  wire             ref_clk,
    input  wire             rst_n,
    // write port
    input  wire             wr_en,
    input  wire [WIDTH-1:0] wr_data,
    input  wire [WIDTH-1:0] wr_mask,
    // stored enables
    output reg  [WIDTH-1:0] hyst_en
);
    genvar i;
    // each bit updates only when its own mask bit is set in the same write
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    hyst_en[i] <= 1'b0;
                end else if (wr_en && wr_mask[i]) begin
                    hyst_en[i] <= wr_data[i];
                end
            end
        end
    endgenerate
endmodule // phr_masked_byte
`default_nettype wire

// file: phr_regs.v
// wishbone register bank for port 3 group b and c pad hysteresis enables
//
// Overview of operation
// - write updates low bit only if mask set
// - clear mask bit leaves low bit unchanged
// - mask bit n+16 pairs with bit n
// - mask half write-only, not stored, reads zero
// - bits 7..0 enable per-pin Schmitt input
// - all enables zero after reset
// - group b at 0xe4, group c at 0xe8
//
// notes for the next engineer
// each register keeps eight enables in bits 7..0 and takes a write mask
// in bits 23..16; a write moves only the enables whose mask bit is set,
// so software can flip one pin without a read-modify-write
// mask bits 31..24 pair with reserved bits 15..8 and are dropped
// the mask half is never stored, so a read shows zero there
// byte lane 0 gates the values and lane 2 gates the mask; a write that
// leaves lane 2 unselected acts as an all-zero mask and changes nothing
// every access is answered one cycle after the edge that takes it: ack
// for the two mapped offsets, err for any other, and an erroring write
// is dropped without side effects
// the answer is registered, which costs one cycle of latency but keeps
// any combinational path from stb to ack out of the bus fabric
// a request is taken only while the sequencer is idle, so a master that
// holds stb through the ack cycle is not counted twice
// the enables leave straight from flops, so the pad cells never see a
// decode glitch while the bus is busy
// limitation: only the two groups of port 3 live here; other offsets
// of the same register file err, so a shared decoder must route them away
// reset clears every enable, leaving all pins without hysteresis
//
// Added by the designer: the Wishbone interface to the registers.
`include "phr_map.vh"
`default_nettype none
module phr_regs #(
    parameter PINS = 8
) (
    // clock and reset
    input  wire             ref_clk,
    input  wire             rst_n,
    // classic wishbone slave
    input  wire             wb_cyc_i,
    input  wire             wb_stb_i,
    input  wire             wb_we_i,
    input  wire [7:0]       wb_adr_i,
    input  wire [3:0]       wb_sel_i,
    input  wire [31:0]      wb_dat_i,
    output reg  [31:0]      wb_dat_o,
    output reg              wb_ack_o,
    output reg              wb_err_o,
    // pad hysteresis enables
    output wire [PINS-1:0]  port3_grpb_hyst_en,
    output wire [PINS-1:0]  port3_grpc_hyst_en,
    // per-pin enables, group b
    output wire             port3_grpb_pin0_hyst_en,
    output wire             port3_grpb_pin1_hyst_en,
    output wire             port3_grpb_pin2_hyst_en,
    output wire             port3_grpb_pin3_hyst_en,
    output wire             port3_grpb_pin4_hyst_en,
    output wire             port3_grpb_pin5_hyst_en,
    output wire             port3_grpb_pin6_hyst_en,
    output wire             port3_grpb_pin7_hyst_en,
    // per-pin enables, group c
    output wire             port3_grpc_pin0_hyst_en,
    output wire             port3_grpc_pin1_hyst_en,
    output wire             port3_grpc_pin2_hyst_en,
    output wire             port3_grpc_pin3_hyst_en,
    output wire             port3_grpc_pin4_hyst_en,
    output wire             port3_grpc_pin5_hyst_en,
    output wire             port3_grpc_pin6_hyst_en,
    output wire             port3_grpc_pin7_hyst_en
);
    // bus answer sequencer states
    localparam [0:0] ST_IDLE = 1'b0;
    localparam [0:0] ST_RESP = 1'b1;

    // request qualification and decode
    wire            req;
    wire            hit_b;
    wire            hit_c;
    wire            hit_any;
    wire            wr_go;
    wire            wr_b;
    wire            wr_c;
    wire [PINS-1:0] mask_eff;
    wire [PINS-1:0] data_eff;
    reg  [31:0]     next_dat;
    reg             state;
    reg             next_state;
    reg             next_ack;
    reg             next_err;

    // a request is taken only from idle, so a held stb counts once
    assign req     = wb_cyc_i && wb_stb_i && (state == ST_IDLE);
    assign hit_b   = (wb_adr_i == `PHR_OFF_GRPB);
    assign hit_c   = (wb_adr_i == `PHR_OFF_GRPC);
    assign hit_any = hit_b || hit_c;
    assign wr_go   = req && wb_we_i;

    // the value lane must be selected for any bit to move
    assign wr_b    = wr_go && hit_b && wb_sel_i[0];
    assign wr_c    = wr_go && hit_c && wb_sel_i[0];

    // a mask bit counts only when its byte lane is selected;
    // mask bits 31..24 pair with reserved bits and are dropped here
    assign mask_eff = wb_dat_i[`PHR_MASK_LSB+PINS-1:`PHR_MASK_LSB]
                      & {PINS{wb_sel_i[2]}};
    assign data_eff = wb_dat_i[`PHR_HYST_LSB+PINS-1:`PHR_HYST_LSB];

    // group b enables
    phr_masked_byte #(.WIDTH(PINS)) u_grpb (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .wr_en   (wr_b),
        .wr_data (data_eff),
        .wr_mask (mask_eff),
        .hyst_en (port3_grpb_hyst_en)
    );

    // group c enables
    phr_masked_byte #(.WIDTH(PINS)) u_grpc (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .wr_en   (wr_c),
        .wr_data (data_eff),
        .wr_mask (mask_eff),
        .hyst_en (port3_grpc_hyst_en)
    );

    // per-pin taps of group b, straight from the enable flops
    assign port3_grpb_pin0_hyst_en = port3_grpb_hyst_en[0];
    assign port3_grpb_pin1_hyst_en = port3_grpb_hyst_en[1];
    assign port3_grpb_pin2_hyst_en = port3_grpb_hyst_en[2];
    assign port3_grpb_pin3_hyst_en = port3_grpb_hyst_en[3];
    assign port3_grpb_pin4_hyst_en = port3_grpb_hyst_en[4];
    assign port3_grpb_pin5_hyst_en = port3_grpb_hyst_en[5];
    assign port3_grpb_pin6_hyst_en = port3_grpb_hyst_en[6];
    assign port3_grpb_pin7_hyst_en = port3_grpb_hyst_en[7];
    // per-pin taps of group c
    assign port3_grpc_pin0_hyst_en = port3_grpc_hyst_en[0];
    assign port3_grpc_pin1_hyst_en = port3_grpc_hyst_en[1];
    assign port3_grpc_pin2_hyst_en = port3_grpc_hyst_en[2];
    assign port3_grpc_pin3_hyst_en = port3_grpc_hyst_en[3];
    assign port3_grpc_pin4_hyst_en = port3_grpc_hyst_en[4];
    assign port3_grpc_pin5_hyst_en = port3_grpc_hyst_en[5];
    assign port3_grpc_pin6_hyst_en = port3_grpc_hyst_en[6];
    assign port3_grpc_pin7_hyst_en = port3_grpc_hyst_en[7];

    // answer sequencer: exactly one answer cycle per taken request
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (req) begin
                    next_state = ST_RESP;
                end
            end
            ST_RESP: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ack for mapped offsets, err for everything else
    always @* begin
        next_ack = req && hit_any;
        next_err = req && !hit_any;
    end

    // read data: mask half and reserved bits read zero
    always @* begin
        next_dat = 32'h0000_0000;
        case ({hit_c, hit_b})
            2'b01: begin
                next_dat[PINS-1:0] = port3_grpb_hyst_en;
            end
            2'b10: begin
                next_dat[PINS-1:0] = port3_grpc_hyst_en;
            end
            default: begin
                next_dat = 32'h0000_0000;
            end
        endcase
    end

    // sequencer state flop
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // single-cycle registered answer; ack and err never overlap
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= next_ack;
            wb_err_o <= next_err;
        end
    end

    // read data stands only in the answer cycle of a read, zero otherwise,
    // so a stale value can never be mistaken for a fresh one
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= next_dat;
        end else begin
            wb_dat_o <= 32'h0000_0000;
        end
    end
endmodule // phr_regs
`default_nettype wire

// file: phr_regs_chk.sv
// checker: assertions on the pad hysteresis bank ports
`default_nettype none
module phr_regs_chk (
    // watched ports
    input wire logic        ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [7:0]  wb_adr_i, port3_grpb_hyst_en, port3_grpc_hyst_en,
    input wire logic [31:0] wb_dat_i, wb_dat_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // taken only while no answer is out, so a held request counts once
    wire logic tk = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire logic wr = tk && wb_we_i && wb_sel_i[0] && wb_sel_i[2];
    wire logic hit = wb_adr_i inside {8'he4, 8'he8};
    wire logic [7:0] nb = port3_grpb_hyst_en & ~wb_dat_i[23:16] | wb_dat_i[7:0] & wb_dat_i[23:16];
    wire logic [7:0] nc = port3_grpc_hyst_en & ~wb_dat_i[23:16] | wb_dat_i[7:0] & wb_dat_i[23:16];
    a_ack_mapped: assert property (tk && hit |=> wb_ack_o)
        else $error("no ack");
    a_err_unmapped: assert property (tk && !hit |=> wb_err_o && !wb_ack_o)
        else $error("no err");
    a_grpb_masked: assert property (wr && wb_adr_i == 8'he4 |=> port3_grpb_hyst_en == $past(nb))
        else $error("group b update");
    a_grpc_masked: assert property (wr && wb_adr_i == 8'he8 |=> port3_grpc_hyst_en == $past(nc))
        else $error("group c update");
    a_grpb_hold: assert property (!(wr && wb_adr_i == 8'he4) |=> $stable(port3_grpb_hyst_en))
        else $error("group b moved");
    a_grpc_hold: assert property (!(wr && wb_adr_i == 8'he8) |=> $stable(port3_grpc_hyst_en))
        else $error("group c moved");
    a_rd_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper bits set");
    a_rd_grpb: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'he4 |-> wb_dat_o[7:0] == port3_grpb_hyst_en)
        else $error("read value");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("long ack");
    cover property (wr && wb_adr_i == 8'he4);
    cover property (wb_err_o);
    cover property (wr && wb_adr_i == 8'he8);
    cover property (wb_ack_o && !wb_we_i);
endmodule // phr_regs_chk
bind phr_regs phr_regs_chk u_chk (.*);
`default_nettype wire

// file: testbench.sv
// testbench: bus accesses to the pad hysteresis bank with expected values
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst_n, cyc, stb, we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] din, rd;
    wire logic [31:0] dout;
    wire logic ack, err;
    wire logic [7:0] hb, hc, pb, pc;
    int bad_count, samples_checked, ticks;
    phr_regs DUT (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(din), .wb_dat_o(dout), .wb_ack_o(ack),
        .wb_err_o(err), .port3_grpb_hyst_en(hb), .port3_grpc_hyst_en(hc),
        .port3_grpb_pin0_hyst_en(pb[0]), .port3_grpb_pin1_hyst_en(pb[1]),
        .port3_grpb_pin2_hyst_en(pb[2]), .port3_grpb_pin3_hyst_en(pb[3]),
        .port3_grpb_pin4_hyst_en(pb[4]), .port3_grpb_pin5_hyst_en(pb[5]),
        .port3_grpb_pin6_hyst_en(pb[6]), .port3_grpb_pin7_hyst_en(pb[7]),
        .port3_grpc_pin0_hyst_en(pc[0]), .port3_grpc_pin1_hyst_en(pc[1]),
        .port3_grpc_pin2_hyst_en(pc[2]), .port3_grpc_pin3_hyst_en(pc[3]),
        .port3_grpc_pin4_hyst_en(pc[4]), .port3_grpc_pin5_hyst_en(pc[5]),
        .port3_grpc_pin6_hyst_en(pc[6]), .port3_grpc_pin7_hyst_en(pc[7]));
    // one classic cycle, sel rising with the rest, held until the answer is sampled
    task automatic acc(input [7:0] a, input w, input [31:0] d, input [3:0] s = 4'hf);
        @(posedge ref_clk);
        {cyc, stb, we, adr, sel, din} <= {2'b11, w, a, s, d};
        do @(posedge ref_clk); while (!(ack || err));
        rd = dout;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic finish_test;
        if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        ref_clk = 0;
        forever #2 ref_clk = ~ref_clk;
    end
    // a hang counts as a mismatch
    always @(posedge ref_clk) if (++ticks > 500) begin
        bad_count++;
        finish_test;
    end
    initial begin
        {rst_n, cyc, stb, we, adr, sel, din} = 0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1;
        chk("en", {hb, hc}, 32'h0);
        acc(8'he4, 1, 32'h00ff00a5);
        chk("b", hb, 32'ha5);
        acc(8'he4, 1, 32'h000f005a);
        acc(8'he4, 0, 32'h0);
        chk("rb", rd, 32'haa);
        chk("pb", pb, 32'haa);
        acc(8'he8, 1, 32'hff80ff80);
        acc(8'he8, 0, 32'h0);
        chk("rc", rd, 32'h80);
        acc(8'he8, 1, 32'h00ff00ff, 4'h4);
        acc(8'hec, 1, 32'h00ff00ff);
        chk("err", err, 32'h1);
        chk("c", hc, 32'h80);
        chk("pc", pc, 32'h80);
        chk("b2", hb, 32'haa);
        finish_test;
    end
endmodule // testbench
`default_nettype wire
